// file: hw/gdt_pkg.sv
package gdt_pkg;
    localparam int CLK_MHZ = 100;
    localparam int MIN_DEAD_NS = 40;
    localparam int MIN_DEAD_CYC = (MIN_DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int SUPPLY_WAIT_US = 20;
    localparam int SUPPLY_WAIT_CYC = SUPPLY_WAIT_US * CLK_MHZ;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_DRIVE = 32'h0000_0004;
    localparam logic [31:0] ADDR_TIMING = 32'h0000_0008;
    localparam logic [31:0] ADDR_AMP = 32'h0000_000c;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
    localparam logic [3:0] LEVEL_MAX = 4'hb;
    localparam logic [3:0] LEVEL_RST = 4'hb;
    localparam logic [7:0] WINDOW_RST = 8'h40;
    localparam logic [7:0] DEAD_RST = 8'h00;
    localparam logic [7:0] BLANK_RST = 8'h00;
    localparam int CTRL_CLR_BIT = 0;
    localparam int CTRL_MODE3_BIT = 1;
    typedef enum logic [1:0] {GAIN_10, GAIN_20, GAIN_40, GAIN_80} gdt_gain_t;
    typedef struct packed {
        logic [3:0] hs_src;
        logic [3:0] hs_snk;
        logic [3:0] ls_src;
        logic [3:0] ls_snk;
    } gdt_drive_t;
    typedef struct packed {
        logic       bias_quarter;
        logic [2:0] cal;
        gdt_gain_t  gain_c;
        gdt_gain_t  gain_b;
        gdt_gain_t  gain_a;
    } gdt_amp_t;
endpackage

// file: hw/gdt_top.sv
// Register access over APB and the register offsets were left to the implementer.
module gdt_top
    import gdt_pkg::*;
#(
    parameter int SUPPLY_WAIT = SUPPLY_WAIT_CYC
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins and analog monitors
    input  wire logic        i_gate_enable,
    input  wire logic        i_supply_uv,
    input  wire logic [2:0]  i_high_side_pwm_input,
    input  wire logic [2:0]  i_low_side_pwm_input,
    input  wire logic [2:0]  i_high_gate_reached,
    input  wire logic [2:0]  i_low_gate_reached,
    // Gate driver controls
    output logic             o_supply_enable,
    output logic [2:0]  o_high_gate_output,
    output logic [2:0]  o_low_gate_output,
    output logic [2:0]  o_strong_current,
    output logic [2:0]  o_gate_hiz,
    output gdt_drive_t  o_drive_level,
    output gdt_amp_t    o_amp_ctrl,
    output logic        o_amp_blank,
    output logic        o_fault
);
    // Synchronise asynchronous pins.
    logic [13:0] sync1, sync2;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {i_gate_enable, i_supply_uv, i_high_side_pwm_input, i_low_side_pwm_input,
                      i_high_gate_reached, i_low_gate_reached};
            sync2 <= sync1;
        end
    end
    logic en_s, uv_s;
    logic [2:0] inh_s, inl_s, hr_s, lr_s;
    assign {en_s, uv_s, inh_s, inl_s, hr_s, lr_s} = sync2;

    // Registers.
    logic       mode3, supply_ok, uv_flag;
    logic [2:0] gd_fault;
    logic [7:0] window, dead, blank;
    gdt_drive_t drive;
    gdt_amp_t   amp;
    logic [31:0] sup_cnt;
    logic        next_mode3, next_supply_ok, next_uv_flag;
    logic [2:0]  next_gd_fault, fault_set;
    logic [7:0]  next_window, next_dead, next_blank;
    gdt_drive_t  next_drive;
    gdt_amp_t    next_amp;
    logic [31:0] next_sup_cnt, next_prdata;
    logic        wr, rd, clr;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign clr = wr && paddr == ADDR_CTRL && pwdata[CTRL_CLR_BIT];
    assign pready = 1'b1;

    function automatic logic [3:0] lvl(input logic [3:0] v);
        lvl = (v > LEVEL_MAX) ? LEVEL_MAX : v;
    endfunction

    always_comb begin
        next_mode3 = mode3;
        next_drive = drive;
        next_window = window;
        next_dead = dead;
        next_blank = blank;
        next_amp = amp;
        next_prdata = prdata;
        if (wr) begin
            case (paddr)
                ADDR_CTRL: next_mode3 = pwdata[CTRL_MODE3_BIT];
                ADDR_DRIVE: next_drive = {lvl(pwdata[15:12]), lvl(pwdata[11:8]),
                                          lvl(pwdata[7:4]), lvl(pwdata[3:0])};
                ADDR_TIMING: begin
                    next_window = pwdata[7:0];
                    next_dead = pwdata[15:8];
                    next_blank = pwdata[23:16];
                end
                ADDR_AMP: next_amp = gdt_amp_t'(pwdata[9:0]);
                default: ;
            endcase
        end
        if (rd) begin
            case (paddr)
                ADDR_CTRL: next_prdata = {30'h0, mode3, 1'b0};
                ADDR_DRIVE: next_prdata = {16'h0, drive};
                ADDR_TIMING: next_prdata = {8'h0, blank, dead, window};
                ADDR_AMP: next_prdata = {22'h0, amp};
                ADDR_STATUS: next_prdata = {26'h0, o_amp_blank, supply_ok, uv_flag, gd_fault};
                default: next_prdata = 32'h0;
            endcase
        end
    end
    logic addr_hit;
    always_comb begin
        case (paddr)
            ADDR_CTRL,
            ADDR_DRIVE,
            ADDR_TIMING,
            ADDR_AMP,
            ADDR_STATUS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end
    // Unmapped addresses answer with an error in the access phase and read as zero.
    assign pslverr = psel && penable && !addr_hit;

    // Supply sequencing and protection.
    always_comb begin
        next_sup_cnt = sup_cnt;
        next_supply_ok = supply_ok;
        if (!en_s) begin
            next_sup_cnt = 32'h0;
            next_supply_ok = 1'b0;
        end else if (sup_cnt < 32'(SUPPLY_WAIT)) begin
            next_sup_cnt = sup_cnt + 32'h1;
        end else begin
            next_supply_ok = 1'b1;
        end
        // A new event in the same cycle as a clear wins, so no fault is lost.
        next_uv_flag = (uv_flag && !clr) || (supply_ok && uv_s);
        // Dropping the enable also clears a latched gate fault.
        next_gd_fault = (gd_fault & {3{!clr && en_s}}) | fault_set;
    end

    // Any latched fault, or a supply that is not yet good, stops all phases.
    logic halt;
    assign halt = !supply_ok || uv_flag || (|gd_fault);

    // Per-phase sequencer.
    logic [2:0] edge_any;
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            typedef enum logic [2:0] {S_OFF, S_WAIT_OFF, S_DEAD, S_DRIVE, S_HOLD} st_t;
            st_t        st, next_st;
            logic [1:0] tgt, next_tgt;
            logic [1:0] out, next_out;
            logic [8:0] cnt, next_cnt;
            logic [1:0] cmd, cmd_q;
            logic       reached;
            logic       outgoing_off;
            // Three-input mode drives the low side as the complement of the high input.
            // In six-input mode both inputs high, like both low, turns the phase off.
            always_comb begin
                if (mode3) begin
                    cmd = {inh_s[p], !inh_s[p]};
                end else begin
                    case ({inh_s[p], inl_s[p]})
                        2'b10: cmd = 2'b10;
                        2'b01: cmd = 2'b01;
                        default: cmd = 2'b00;
                    endcase
                end
            end
            // The target is reached when both gate monitors agree with the commanded pair.
            always_comb begin
                reached = 1'b1;
                if (hr_s[p] != tgt[1]) reached = 1'b0;
                if (lr_s[p] != tgt[0]) reached = 1'b0;
            end
            // The side being released must report off before the other side may rise.
            assign outgoing_off = (out & ~tgt) == 2'b00 && (tgt[1] ? !lr_s[p] : !hr_s[p]);
            always_comb begin
                next_st = st;
                next_tgt = tgt;
                next_out = out;
                next_cnt = (cnt != 9'h0) ? cnt - 9'h1 : cnt;
                fault_set[p] = 1'b0;
                if (halt) begin
                    next_st = S_OFF;
                    next_out = 2'b00;
                    next_tgt = 2'b00;
                end else if (cmd != cmd_q || (st == S_OFF && cmd != 2'b00)) begin
                    // A new command reloads the counter with the full window; the outgoing
                    // gate is dropped at once and the incoming one waits.
                    next_tgt = cmd;
                    next_out = out & cmd;
                    next_cnt = {1'b0, window};
                    next_st = (cmd & ~out) != 2'b00 ? S_WAIT_OFF : S_DRIVE;
                end else begin
                    case (st)
                        S_WAIT_OFF: if (reached || outgoing_off) begin
                            next_st = S_DEAD;
                            next_cnt = 9'(MIN_DEAD_CYC) + {1'b0, dead};
                        end
                        S_DEAD: if (cnt == 9'h0) begin
                            next_out = tgt;
                            next_st = S_DRIVE;
                            next_cnt = {1'b0, window};
                        end
                        // At the end of the window the gate must have settled, or the phase trips.
                        S_DRIVE: if (cnt == 9'h0) begin
                            if (reached) next_st = S_HOLD;
                            else begin
                                fault_set[p] = 1'b1;
                                next_st = S_OFF;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    st <= S_OFF;
                    tgt <= 2'b00;
                    out <= 2'b00;
                    cnt <= 9'h0;
                    cmd_q <= 2'b00;
                end else begin
                    st <= next_st;
                    tgt <= next_tgt;
                    out <= next_out;
                    cnt <= next_cnt;
                    cmd_q <= cmd;
                end
            end
            assign o_high_gate_output[p] = out[1];
            assign o_low_gate_output[p] = out[0];
            assign o_strong_current[p] = (st == S_DRIVE);
            assign o_gate_hiz[p] = gd_fault[p] || halt;
            assign edge_any[p] = (next_out != out);
        end
    endgenerate

    // Shared amplifier blanking.
    logic [7:0] blk_cnt, next_blk_cnt;
    // Every gate edge of any phase reloads the one shared counter, so a
    // burst of edges keeps the amplifiers blanked until the last one settles.
    always_comb begin
        if (|edge_any) begin
            next_blk_cnt = blank;
        end else if (blk_cnt != 8'h0) begin
            next_blk_cnt = blk_cnt - 8'h1;
        end else begin
            next_blk_cnt = 8'h0;
        end
    end
    assign o_amp_blank = (blk_cnt != 8'h0);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mode3 <= 1'b0;
            drive <= {LEVEL_RST, LEVEL_RST, LEVEL_RST, LEVEL_RST};
            window <= WINDOW_RST;
            dead <= DEAD_RST;
            blank <= BLANK_RST;
            amp <= '0;
            prdata <= 32'h0;
            sup_cnt <= 32'h0;
            supply_ok <= 1'b0;
            uv_flag <= 1'b0;
            gd_fault <= 3'h0;
            blk_cnt <= 8'h0;
        end else begin
            mode3 <= next_mode3;
            drive <= next_drive;
            window <= next_window;
            dead <= next_dead;
            blank <= next_blank;
            amp <= next_amp;
            prdata <= next_prdata;
            sup_cnt <= next_sup_cnt;
            supply_ok <= next_supply_ok;
            uv_flag <= next_uv_flag;
            gd_fault <= next_gd_fault;
            blk_cnt <= next_blk_cnt;
        end
    end
    // The low-side supply follows the synchronised enable directly.
    assign o_supply_enable = en_s;
    assign o_drive_level = drive;
    assign o_amp_ctrl = amp;
    assign o_fault = uv_flag || (|gd_fault);
endmodule // gdt_top

// file: tb/gdt_gate_model.sv
module gdt_gate_model (
    input  wire logic       i_clk,
    input  wire logic [2:0] i_hi_cmd,
    input  wire logic [2:0] i_lo_cmd,
    input  wire logic [2:0] i_stuck,
    input  wire logic [2:0] i_dly,
    output logic      [2:0] o_hi_ok,
    output logic      [2:0] o_lo_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0][5:0] hist = '0;
    always_ff @(posedge i_clk) begin
        hist <= {hist[6:0], i_lo_cmd, i_hi_cmd};
    end
    // Gates settle only after the chosen delay; a shorted high gate never rises.
    assign o_hi_ok = hist[i_dly][2:0] & ~i_stuck;
    assign o_lo_ok = hist[i_dly][5:3];
endmodule // gdt_gate_model

// file: tb/gdt_top_asserts.sv
module gdt_top_asserts
    import gdt_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        i_gate_enable,
    input wire logic        i_supply_uv,
    input wire logic        o_supply_enable,
    input wire logic [2:0]  o_high_gate_output,
    input wire logic [2:0]  o_low_gate_output,
    input wire logic [2:0]  o_strong_current,
    input wire logic [2:0]  o_gate_hiz,
    input gdt_drive_t       o_drive_level,
    input wire logic        o_amp_blank,
    input wire logic        o_fault
);
    logic [7:0] win;
    logic [7:0] next_win;
    logic [8:0] scnt;
    logic [8:0] next_scnt;
    logic       wr;
    assign wr = psel && penable && pwrite;
    always_comb begin
        next_win = (wr && paddr == ADDR_TIMING) ? pwdata[7:0] : win;
        next_scnt = o_strong_current[0] ? scnt + 9'h1 : 9'h0;
    end
    always_ff @(posedge i_ref_clk) begin
        win <= i_rst ? WINDOW_RST : next_win;
        scnt <= i_rst ? 9'h0 : next_scnt;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_no_shoot: assert property ((o_high_gate_output & o_low_gate_output) == 3'h0)
        else $error("both gates of a phase on");
    a_dead_min: assert property ((o_high_gate_output & ~$past(o_high_gate_output) & $past(o_low_gate_output, 4)) == 3'h0)
        else $error("high gate rose inside dead time");
    a_supply_off: assert property (!i_gate_enable [*4] |=> !o_supply_enable)
        else $error("supply enabled while enable low");
    a_fault_hiz: assert property (o_fault [*2] |-> o_gate_hiz == 3'h7)
        else $error("fault without tristate");
    a_fault_kept: assert property ($fell(o_fault) |-> $past(wr && paddr == ADDR_CTRL && pwdata[0]) || !o_supply_enable)
        else $error("fault dropped without clear");
    a_strong_bound: assert property (scnt <= {1'b0, win} + 9'h2)
        else $error("strong current beyond window");
    a_level_clip: assert property (o_drive_level.hs_src <= LEVEL_MAX && o_drive_level.ls_snk <= LEVEL_MAX)
        else $error("drive level above top setting");
    a_uv_fault: assert property ((o_gate_hiz == 3'h0 && i_supply_uv) [*4] |=> o_fault)
        else $error("undervoltage not flagged");
    c_fault: cover property ($rose(o_fault));
    c_blank: cover property ($rose(o_amp_blank));
    c_high: cover property ($rose(o_high_gate_output[0]));
endmodule // gdt_top_asserts
bind gdt_top gdt_top_asserts chk_i (.*);

// file: tb/gdt_top_tb.sv
module gdt_top_tb;
    import gdt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk, i_rst, psel, penable, pwrite, pready, pslverr;
    logic        i_gate_enable, i_supply_uv, o_supply_enable, o_amp_blank, o_fault;
    logic [31:0] paddr, pwdata, prdata, v, rs = 32'h53b8188c;
    logic [2:0]  i_high_side_pwm_input, i_low_side_pwm_input, i_high_gate_reached, i_low_gate_reached;
    logic [2:0]  o_high_gate_output, o_low_gate_output, o_strong_current, o_gate_hiz, stuck, dly;
    gdt_drive_t  o_drive_level;
    gdt_amp_t    o_amp_ctrl;
    int          error_cnt = 0, n_checks = 0;
    logic [31:0] q[$];
    gdt_top #(.SUPPLY_WAIT(10)) uut (.*);
    gdt_gate_model gm (.i_clk(i_ref_clk), .i_hi_cmd(o_high_gate_output), .i_lo_cmd(o_low_gate_output),
        .i_stuck(stuck), .i_dly(dly), .o_hi_ok(i_high_gate_reached), .o_lo_ok(i_low_gate_reached));
    initial begin
        i_ref_clk = 0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [3:0] cl(input logic [3:0] x);
        return x > LEVEL_MAX ? LEVEL_MAX : x;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge i_ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        penable <= 1;
        do @(posedge i_ref_clk); while (pready !== 1);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [31:0] a, e);
        q.push_back(e);
        apb(0, a, 0);
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic drv();
        v = xs();
        v = {16'h0, 4'hf, v[11:0]};
        apb(1, ADDR_DRIVE, v);
        wt(1);
        chk("drive", {16'h0, cl(v[15:12]), cl(v[11:8]), cl(v[7:4]), cl(v[3:0])}, o_drive_level);
    endtask
    always @(posedge i_ref_clk) begin
        if (psel && penable && !pwrite && pready) chk("prdata", q.pop_front(), prdata);
        if (psel && penable && pready)
            chk("pslverr", {31'h0, !(paddr inside {ADDR_CTRL, ADDR_DRIVE, ADDR_TIMING, ADDR_AMP, ADDR_STATUS})},
                {31'h0, pslverr});
    end
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        {psel, penable, pwrite, i_gate_enable, i_supply_uv, paddr, pwdata} = '0;
        {i_high_side_pwm_input, i_low_side_pwm_input, stuck} = '0;
        dly = 3'h3;
        i_rst = 1;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 0;
        wt(6);
        chk("supply_en", 0, o_supply_enable);
        rd(ADDR_DRIVE, 32'h0000bbbb);
        rd(ADDR_TIMING, 32'h00000040);
        rd(32'h00000040, 32'h0);
        for (int k = 0; k < 4; k++) begin
            v = xs();
            v = {22'h0, v[9:6], k[1:0], k[1:0], k[1:0]};
            apb(1, ADDR_AMP, v);
            wt(1);
            chk("amp", v, {22'h0, o_amp_ctrl});
        end
        drv();
        apb(1, ADDR_TIMING, 32'h00200208);
        i_gate_enable <= 1;
        for (int k = 0; k < 100 && o_gate_hiz !== 0; k++) wt(1);
        chk("supply_en", 1, o_supply_enable);
        drv();
        $display("test config done");
        @(posedge i_ref_clk);
        i_high_side_pwm_input <= 3'h1;
        for (int k = 0; k < 100 && o_high_gate_output[0] !== 1; k++) wt(1);
        wt(1);
        chk("blank", 1, o_amp_blank);
        @(posedge i_ref_clk);
        i_high_side_pwm_input <= 3'h0;
        i_low_side_pwm_input <= 3'h1;
        for (int k = 0; k < 100 && o_low_gate_output[0] !== 1; k++) wt(1);
        chk("hs_off", 0, i_high_gate_reached[0]);
        wt(28);
        chk("blank", 1, o_amp_blank);
        wt(10);
        chk("blank", 0, o_amp_blank);
        $display("test switching done");
        @(posedge i_ref_clk);
        stuck <= 3'h2;
        i_high_side_pwm_input <= 3'h2;
        for (int k = 0; k < 100 && o_fault !== 1; k++) wt(1);
        chk("hiz", 7, o_gate_hiz);
        wt(40);
        rd(ADDR_STATUS, 32'h00000012);
        stuck <= 3'h0;
        i_high_side_pwm_input <= 3'h0;
        apb(1, ADDR_CTRL, 32'h1);
        wt(4);
        chk("fault", 0, o_fault);
        @(posedge i_ref_clk);
        i_supply_uv <= 1;
        wt(12);
        chk("fault", 1, o_fault);
        @(posedge i_ref_clk);
        i_supply_uv <= 0;
        wt(4);
        apb(1, ADDR_CTRL, 32'h1);
        wt(4);
        chk("fault", 0, o_fault);
        $display("test faults done");
        apb(1, ADDR_CTRL, 32'h2);
        rd(ADDR_CTRL, 32'h2);
        i_low_side_pwm_input <= 3'h0;
        for (int k = 0; k < 100 && o_low_gate_output !== 3'h7; k++) wt(1);
        chk("mode3_low", 32'h7, {29'h0, o_low_gate_output});
        chk("mode3_high", 32'h0, {29'h0, o_high_gate_output});
        $display("test mode3 done");
        stop_test();
    end
endmodule // gdt_top_tb
